/* File: pmc_defs.svh */
// Offsets, field positions, reset values and read masks for the platform misc control registers
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PMC_IDX_W              7
`define PMC_IDX_PRESENCE       7'h0A
`define PMC_IDX_PLATFORM       7'h0C
`define PMC_IDX_COMPUTE        7'h40

// ----------------------------------------------------------------------------
// Platform control field positions
// ----------------------------------------------------------------------------
`define PMC_BIT_STALL_BUSY     16
`define PMC_BIT_SPEC_DIS       15
`define PMC_BIT_DATA_SPEC      14
`define PMC_BIT_CACHE_DIS      13
`define PMC_BIT_INSTR_CDIS     12
`define PMC_BIT_DATA_CDIS      11
`define PMC_BIT_CACHE_CLEAR    10
`define PMC_BIT_ARB_POLICY     9

// ----------------------------------------------------------------------------
// Compute operation field positions
// ----------------------------------------------------------------------------
`define PMC_BIT_WAKE_INT       2
`define PMC_BIT_CPO_ACK        1
`define PMC_BIT_CPO_REQ        0

// ----------------------------------------------------------------------------
// Reset values and read masks
// ----------------------------------------------------------------------------
`define PMC_PLATFORM_RESET     32'h0000_0000
`define PMC_COMPUTE_RESET      32'h0000_0000
`define PMC_PLATFORM_RD_MASK   32'h0001_FA00
`define PMC_COMPUTE_RD_MASK    32'h0000_0007
`define PMC_UNMAPPED_DATA      32'h0000_0000

`endif

/* File: pmc_pkg.sv */
// Types shared by the platform misc control registers
package pmc_pkg;

	// ------------------------------------------------------------------------
	// Controls towards flash controller and crossbar arbiter
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic specInstr;
		logic specData;
		logic cacheInstr;
		logic cacheData;
		logic stallOnBusy;
		logic cacheClear;
		logic roundRobin;
	} pmc_flash_ctl_t;

	// ------------------------------------------------------------------------
	// Synchroniser state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} pmc_sync_t;

	// ------------------------------------------------------------------------
	// Register bank state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic           waitReq;
		logic [31:0]    rdata;
		logic           stallBusy;
		logic           specDisable;
		logic           dataSpecEnable;
		logic           cacheDisable;
		logic           instrCacheDisable;
		logic           dataCacheDisable;
		logic           arbPolicy;
		logic           wakeOnInt;
		logic           cpoRequest;
		pmc_flash_ctl_t flash;
	} pmc_state_t;

endpackage

/* File: pmc_sync.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps

module pmc_sync
(
	input  logic mclk,
	input  logic rst_n,
	input  logic asyncIn,
	output logic syncOut
);

	pmc_pkg::pmc_sync_t st;
	pmc_pkg::pmc_sync_t next_st;

	// ------------------------------------------------------------------------
	// Chain; s1 feeds only s2
	// ------------------------------------------------------------------------
	always_comb
	begin
		next_st    = st;
		next_st.s1 = asyncIn;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3)
		begin
			next_st.level = st.s3;
		end
		if (!rst_n)
		begin
			next_st = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		st <= next_st;
	end

	assign syncOut = st.level;

endmodule

/* File: pmc_regs.sv */
// Platform misc control register bank on an Avalon-MM slave
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_regs
(
	input  logic                    mclk,
	input  logic                    rst_n,
	input  logic [8:0]              address,
	input  logic                    read,
	input  logic                    write,
	input  logic [31:0]             writedata,
	input  logic [3:0]              byteenable,
	output logic [31:0]             readdata,
	output logic                    waitrequest,
	input  logic [7:0]              masterPresent,
	input  logic                    vectorFetch,
	input  logic                    computeOpAck,
	output logic                    computeOpRequest,
	output pmc_pkg::pmc_flash_ctl_t flashCtl
);

	pmc_pkg::pmc_state_t st;
	pmc_pkg::pmc_state_t next_st;
	logic                ackLevel;
	logic                rdTake;
	logic                wrTake;
	logic [6:0]          idx;

	// ------------------------------------------------------------------------
	// Acknowledge status input
	// ------------------------------------------------------------------------
	pmc_sync u_ack_sync
	(
		.mclk    (mclk),
		.rst_n   (rst_n),
		.asyncIn (computeOpAck),
		.syncOut (ackLevel)
	);

	// ------------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------------
	function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
		hit = (a == target);
	endfunction

	function automatic pmc_pkg::pmc_flash_ctl_t decode(input pmc_pkg::pmc_state_t s);
		pmc_pkg::pmc_flash_ctl_t f;
		f             = '0;
		f.specInstr   = !s.specDisable;
		f.specData    = !s.specDisable && s.dataSpecEnable;
		f.cacheInstr  = !s.cacheDisable && !s.instrCacheDisable;
		f.cacheData   = !s.cacheDisable && !s.dataCacheDisable;
		f.stallOnBusy = s.stallBusy;
		f.roundRobin  = s.arbPolicy;
		f.cacheClear  = s.flash.cacheClear;
		decode        = f;
	endfunction

	function automatic logic [31:0] read_word(input logic [6:0] a,
		input pmc_pkg::pmc_state_t s, input logic [7:0] pres, input logic ack);
		logic [31:0] w;
		w = `PMC_UNMAPPED_DATA;
		if (hit(a, `PMC_IDX_PRESENCE))
		begin
			w = {24'h00_0000, pres};
		end
		else if (hit(a, `PMC_IDX_PLATFORM))
		begin
			w[`PMC_BIT_STALL_BUSY]  = s.stallBusy;
			w[`PMC_BIT_SPEC_DIS]    = s.specDisable;
			w[`PMC_BIT_DATA_SPEC]   = s.dataSpecEnable;
			w[`PMC_BIT_CACHE_DIS]   = s.cacheDisable;
			w[`PMC_BIT_INSTR_CDIS]  = s.instrCacheDisable;
			w[`PMC_BIT_DATA_CDIS]   = s.dataCacheDisable;
			w[`PMC_BIT_ARB_POLICY]  = s.arbPolicy;
			w = w & `PMC_PLATFORM_RD_MASK;
		end
		else if (hit(a, `PMC_IDX_COMPUTE))
		begin
			w[`PMC_BIT_WAKE_INT] = s.wakeOnInt;
			w[`PMC_BIT_CPO_ACK]  = ack;
			w[`PMC_BIT_CPO_REQ]  = s.cpoRequest;
			w = w & `PMC_COMPUTE_RD_MASK;
		end
		read_word = w;
	endfunction

	// ------------------------------------------------------------------------
	// Bus slave and register update
	// ------------------------------------------------------------------------
	assign idx    = address[8:2];
	assign rdTake = read && st.waitReq;
	assign wrTake = write && !st.waitReq;

	always_comb
	begin
		next_st                  = st;
		next_st.waitReq          = !((read || write) && st.waitReq);
		next_st.flash.cacheClear = 1'h0;
		if (rdTake)
		begin
			next_st.rdata = read_word(idx, st, masterPresent, ackLevel);
		end
		if (wrTake && hit(idx, `PMC_IDX_PLATFORM))
		begin
			if (byteenable[2])
			begin
				next_st.stallBusy = writedata[`PMC_BIT_STALL_BUSY];
			end
			if (byteenable[1])
			begin
				next_st.specDisable       = writedata[`PMC_BIT_SPEC_DIS];
				next_st.dataSpecEnable    = writedata[`PMC_BIT_DATA_SPEC];
				next_st.cacheDisable      = writedata[`PMC_BIT_CACHE_DIS];
				next_st.instrCacheDisable = writedata[`PMC_BIT_INSTR_CDIS];
				next_st.dataCacheDisable  = writedata[`PMC_BIT_DATA_CDIS];
				next_st.arbPolicy         = writedata[`PMC_BIT_ARB_POLICY];
				next_st.flash.cacheClear  = writedata[`PMC_BIT_CACHE_CLEAR];
			end
		end
		if (wrTake && hit(idx, `PMC_IDX_COMPUTE) && byteenable[0])
		begin
			next_st.wakeOnInt  = writedata[`PMC_BIT_WAKE_INT];
			next_st.cpoRequest = writedata[`PMC_BIT_CPO_REQ];
		end
		// Vector fetch wins over a simultaneous software set when wakeOnInt is already set
		if (vectorFetch && st.wakeOnInt)
		begin
			next_st.cpoRequest = 1'h0;
		end
		next_st.flash            = decode(next_st);
		if (!rst_n)
		begin
			next_st                   = '0;
			next_st.waitReq           = 1'h1;
			next_st.stallBusy         = 1'(`PMC_PLATFORM_RESET >> `PMC_BIT_STALL_BUSY);
			next_st.cpoRequest        = 1'(`PMC_COMPUTE_RESET >> `PMC_BIT_CPO_REQ);
			next_st.flash.specInstr   = 1'h1;
			next_st.flash.cacheInstr  = 1'h1;
			next_st.flash.cacheData   = 1'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		st <= next_st;
	end

	assign readdata         = st.rdata;
	assign waitrequest      = st.waitReq;
	assign computeOpRequest = st.cpoRequest;
	assign flashCtl         = st.flash;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest low phase not exactly one cycle");
	a_presence_read: assert property (rdTake && hit(idx, `PMC_IDX_PRESENCE) |=> readdata == {24'h00_0000, $past(masterPresent)})
		else $error("presence read wrong");
	a_presence_bits: assert property (rdTake && hit(idx, `PMC_IDX_PRESENCE) && masterPresent[0] |=> readdata[0])
		else $error("presence bit lost");
	a_spec_decode: assert property (flashCtl.specData |-> flashCtl.specInstr && !st.specDisable && st.dataSpecEnable)
		else $error("speculation decode wrong");
	a_cache_decode: assert property (st.cacheDisable |-> !flashCtl.cacheInstr && !flashCtl.cacheData)
		else $error("cache not off when disabled");
	a_cache_instr: assert property (!st.cacheDisable && !st.instrCacheDisable |-> flashCtl.cacheInstr)
		else $error("instruction caching wrongly off");
	a_stall_write: assert property (wrTake && hit(idx, `PMC_IDX_PLATFORM) && byteenable[2] |=> flashCtl.stallOnBusy == $past(writedata[16]))
		else $error("stall enable not written");
	a_clear_pulse: assert property (wrTake && hit(idx, `PMC_IDX_PLATFORM) && byteenable[1] && writedata[10] |=> flashCtl.cacheClear ##1 !flashCtl.cacheClear)
		else $error("cache clear not a single pulse");
	a_arb_write: assert property (wrTake && hit(idx, `PMC_IDX_PLATFORM) && byteenable[1] |=> flashCtl.roundRobin == $past(writedata[9]))
		else $error("arbitration policy not written");
	a_reserved_zero: assert property (rdTake && hit(idx, `PMC_IDX_PLATFORM) |=> (readdata & ~32'h0001_FA00) == 32'h0000_0000)
		else $error("reserved platform bits not zero");
	a_cpo_reserved: assert property (rdTake && hit(idx, `PMC_IDX_COMPUTE) |=> readdata[31:3] == 29'h0000_0000)
		else $error("reserved compute bits not zero");
	a_req_set: assert property (wrTake && hit(idx, `PMC_IDX_COMPUTE) && byteenable[0] && !(vectorFetch && st.wakeOnInt) |=> computeOpRequest == $past(writedata[0]))
		else $error("request not written");
	a_wake_clear: assert property (vectorFetch && st.wakeOnInt |=> !computeOpRequest)
		else $error("vector fetch did not clear request");
	a_req_hold: assert property (vectorFetch && !st.wakeOnInt && !(wrTake && hit(idx, `PMC_IDX_COMPUTE)) |=> $stable(computeOpRequest))
		else $error("request changed without cause");
	a_ack_read: assert property (rdTake && hit(idx, `PMC_IDX_COMPUTE) |=> readdata[1] == $past(ackLevel))
		else $error("acknowledge read wrong");
	a_ack_follow: assert property (computeOpAck[*5] |=> ackLevel)
		else $error("acknowledge not sampled");
	a_reset_state: assert property (@(posedge mclk) disable iff (1'h0) $rose(rst_n) |-> flashCtl.specInstr && !flashCtl.specData && flashCtl.cacheInstr && flashCtl.cacheData && !computeOpRequest)
		else $error("reset values wrong");

	c_platform_write: cover property (wrTake && hit(idx, `PMC_IDX_PLATFORM));
	c_cache_clear: cover property (flashCtl.cacheClear);
	c_wake_clear: cover property (computeOpRequest && vectorFetch && st.wakeOnInt);
	c_ack_read: cover property (rdTake && hit(idx, `PMC_IDX_COMPUTE) && ackLevel);

endmodule

/* File: pmc_partner.sv */
// Behavioural compute-operation logic and flash cache-clear observer
`timescale 1ns/1ps

module pmc_partner
#(
	parameter int ACK_DELAY = 6
)
(
	input  logic                    mclk,
	input  logic                    rst_n,
	input  logic                    computeOpRequest,
	input  pmc_pkg::pmc_flash_ctl_t flashCtl,
	output logic                    computeOpAck,
	output logic [7:0]              clearCount
);
	int waitCnt;

	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			computeOpAck <= 1'b0;
			waitCnt      <= 0;
			clearCount   <= 8'h00;
		end
		else
		begin
			// Entry or exit completes some cycles after the request moves
			if (computeOpRequest !== computeOpAck && waitCnt < ACK_DELAY)
				waitCnt <= waitCnt + 1;
			else
			begin
				waitCnt      <= 0;
				computeOpAck <= computeOpRequest;
			end
			if (flashCtl.cacheClear)
				clearCount <= clearCount + 8'h01;
		end
	end
endmodule

/* File: pmc_regs_tb_top.sv */
// Self-checking testbench for the platform misc control register bank
`timescale 1ns/1ps
`include "pmc_defs.svh"

module pmc_regs_tb_top;
	logic                    mclk          = 1'b0;
	logic                    rst_n         = 1'b0;
	logic [8:0]              address       = 9'h000;
	logic                    read          = 1'b0;
	logic                    write         = 1'b0;
	logic [31:0]             writedata     = 32'h0000_0000;
	logic [3:0]              byteenable    = 4'h0;
	logic [7:0]              masterPresent = 8'h00;
	logic                    vectorFetch   = 1'b0;
	logic [31:0]             lfsrState     = 32'h1135_30F2;
	logic [31:0]             readdata;
	logic                    waitrequest;
	logic                    computeOpAck;
	logic                    computeOpRequest;
	pmc_pkg::pmc_flash_ctl_t flashCtl;
	logic [7:0]              clearCount;
	logic [7:0]              clears;
	logic [31:0]             plat;
	logic [31:0]             expQ[$];
	int                      fails;
	int                      comparisons;

	pmc_regs dut_u (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .masterPresent(masterPresent), .vectorFetch(vectorFetch),
		.computeOpAck(computeOpAck), .computeOpRequest(computeOpRequest), .flashCtl(flashCtl));
	pmc_partner #(.ACK_DELAY(6)) partner_u (.mclk(mclk), .rst_n(rst_n), .flashCtl(flashCtl),
		.computeOpRequest(computeOpRequest), .computeOpAck(computeOpAck),
		.clearCount(clearCount));

	always #25 mclk = ~mclk;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] nextRand();
		lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
		return lfsrState;
	endfunction

	function automatic pmc_pkg::pmc_flash_ctl_t ctlOf(logic [31:0] p, logic clr);
		pmc_pkg::pmc_flash_ctl_t c;
		c.specInstr   = !p[15];
		c.specData    = !p[15] && p[14];
		c.cacheInstr  = !p[13] && !p[12];
		c.cacheData   = !p[13] && !p[11];
		c.stallOnBusy = p[16];
		c.cacheClear  = clr;
		c.roundRobin  = p[9];
		return c;
	endfunction

	task automatic checkWord(string what, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic checkLine(string what, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic busCycle(logic wr, logic [6:0] idx, logic [31:0] d, logic [3:0] be);
		@(posedge mclk);
		address    <= {idx, 2'b00};
		write      <= wr;
		read       <= !wr;
		writedata  <= d;
		byteenable <= be;
		do
		begin
			@(posedge mclk);
		end
		while (waitrequest !== 1'b0);
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rd(logic [6:0] idx, logic [31:0] e);
		expQ.push_back(e);
		busCycle(1'b0, idx, nextRand(), 4'hF);
	endtask

	task automatic waitAck(logic v);
		int n;
		n = 0;
		while (computeOpAck !== v && n < 200)
		begin
			@(posedge mclk);
			n++;
		end
		checkLine("computeOpAck", {7'h00, v}, {7'h00, computeOpAck});
		repeat (6) @(posedge mclk);
	endtask

	task automatic pulseVector();
		@(posedge mclk);
		vectorFetch <= 1'b1;
		@(posedge mclk);
		vectorFetch <= 1'b0;
		#1;
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Read data monitor and watchdog
	// ------------------------------------------------------------------
	always @(posedge mclk)
		if (read === 1'b1 && waitrequest === 1'b0)
			checkWord("readdata", expQ.pop_front(), readdata);

	initial
	begin
		repeat (5000) @(posedge mclk);
		fails++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		clears = 8'h00;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		checkLine("flashCtl", {1'b0, ctlOf(32'h0, 1'b0)}, {1'b0, flashCtl});
		checkLine("computeOpRequest", 8'h00, {7'h00, computeOpRequest});
		rd(`PMC_IDX_PLATFORM, `PMC_PLATFORM_RESET);
		rd(`PMC_IDX_COMPUTE, `PMC_COMPUTE_RESET);
		$display("Test reset values done");
		for (int i = 0; i < 6; i++)
		begin
			plat = nextRand();
			masterPresent <= plat[7:0];
			busCycle(1'b1, `PMC_IDX_PRESENCE, 32'hFFFF_FFFF, 4'hF);
			rd(`PMC_IDX_PRESENCE, {24'h000000, plat[7:0]});
		end
		$display("Test master presence done");
		for (int i = 0; i < 16; i++)
		begin
			plat = nextRand();
			plat[16:13] = i[3:0];
			clears = clears + {7'h00, plat[10]};
			busCycle(1'b1, `PMC_IDX_PLATFORM, plat, 4'hF);
			#1;
			checkLine("flashCtl", {1'b0, ctlOf(plat, plat[10])}, {1'b0, flashCtl});
			rd(`PMC_IDX_PLATFORM, plat & `PMC_PLATFORM_RD_MASK);
			checkLine("flashCtl", {1'b0, ctlOf(plat, 1'b0)}, {1'b0, flashCtl});
		end
		checkLine("clearCount", clears, clearCount);
		$display("Test platform control done");
		busCycle(1'b1, `PMC_IDX_PLATFORM, 32'h0001_FFFF, 4'hD);
		plat = (plat & 32'h0000_FA00) | 32'h0001_0000;
		rd(`PMC_IDX_PLATFORM, plat);
		checkLine("clearCount", clears, clearCount);
		busCycle(1'b1, 7'h0D, 32'hFFFF_FFFF, 4'hF);
		rd(7'h01, `PMC_UNMAPPED_DATA);
		rd(`PMC_IDX_PLATFORM, plat);
		$display("Test byte lanes and unmapped done");
		busCycle(1'b1, `PMC_IDX_COMPUTE, 32'h0000_0001, 4'hF);
		#1;
		checkLine("computeOpRequest", 8'h01, {7'h00, computeOpRequest});
		rd(`PMC_IDX_COMPUTE, 32'h0000_0001);
		waitAck(1'b1);
		rd(`PMC_IDX_COMPUTE, 32'h0000_0003);
		pulseVector();
		checkLine("computeOpRequest", 8'h01, {7'h00, computeOpRequest});
		busCycle(1'b1, `PMC_IDX_COMPUTE, 32'hFFFF_FFFD, 4'hF);
		rd(`PMC_IDX_COMPUTE, 32'h0000_0007);
		pulseVector();
		checkLine("computeOpRequest", 8'h00, {7'h00, computeOpRequest});
		waitAck(1'b0);
		rd(`PMC_IDX_COMPUTE, 32'h0000_0004);
		$display("Test compute operation done");
		complete_run();
	end
endmodule
